/* hdl/ssp_params.svh */
/* Offsets, field positions, reset values and timing counts of the sync serial port.
   Assumes a 125 MHz system clock and one register per aligned 32-bit Wishbone word. */
`ifndef SSP_PARAMS_SVH
`define SSP_PARAMS_SVH
`define SSP_A_BUF 8'h00
`define SSP_A_CON1 8'h04
`define SSP_A_STAT 8'h08
`define SSP_A_CMD 8'h0C
`define SSP_A_IRQ_ST 8'h10
`define SSP_A_IRQ_CLR 8'h14
`define SSP_A_IRQ_EN 8'h18
`define SSP_B_COLL 7
`define SSP_B_OV 6
`define SSP_B_EN 5
`define SSP_B_POL 4
`define SSP_B_SPH 7
`define SSP_B_CKE 6
`define SSP_B_SEN 0
`define SSP_B_RSEN 1
`define SSP_B_PEN 2
`define SSP_B_RCEN 3
`define SSP_B_ACKEN 4
`define SSP_B_ACKDT 5
`define SSP_I_XFER 0
`define SSP_I_COLL 1
`define SSP_I_OV 2
`define SSP_M_SPI_MST 4'h0
`define SSP_M_SPI_SLV 4'h4
`define SSP_M_I2C_MST 4'h8
`define SSP_RST_REG 8'h00
`define SSP_RST_IRQ 3'h0
`define SSP_CLK_NS 8
`define SSP_QTR_RUN_NS 40
`define SSP_QTR_LP_NS 400
`define SSP_DIV_RUN ((`SSP_QTR_RUN_NS + `SSP_CLK_NS - 1) / `SSP_CLK_NS)
`define SSP_DIV_LP ((`SSP_QTR_LP_NS + `SSP_CLK_NS - 1) / `SSP_CLK_NS)
`endif

/* hdl/ssp_pkg.sv */
/* Types shared by the sync serial port: bus carriers and engine states.
   Assumes nothing from the constants header; widths and state codes are set here. */
package ssp_pkg;
   // classic wishbone request as seen by the slave
   typedef struct packed {
      logic cyc;
      logic stb;
      logic we;
      logic [7:0] adr;
      logic [3:0] sel;
      logic [31:0] dat;
   } ssp_wb_req_t;
   // slave answer
   typedef struct packed {
      logic ack;
      logic [31:0] dat;
   } ssp_wb_rsp_t;
   // engine states, gray along idle-start-bit-ack-stop
   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_START = 3'b001,
      ST_BIT = 3'b011,
      ST_ACK = 3'b010,
      ST_STOP = 3'b110
   } ssp_st_t;
endpackage : ssp_pkg

/* hdl/ssp_top.sv */
/* Sync serial port: serial master/slave and two-wire master behind a Wishbone slave.
   Assumes a power controller on clk_i giving sleep/idle/low-power levels; pins are
   synchronised here, and the serial clock of a slave is sampled, not used as a clock. */
// The implementer's own choices: the Wishbone interface to the registers and the placing of the registers.
`include "ssp_params.svh"
module ssp_top #(
   parameter int DIV_RUN = `SSP_DIV_RUN,
   parameter int DIV_LP = `SSP_DIV_LP
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire ssp_pkg::ssp_wb_req_t wb_i,
   output ssp_pkg::ssp_wb_rsp_t wb_o,
   input wire logic sleep_i,
   input wire logic idle_i,
   input wire logic lowpow_i,
   input wire logic sck_i,
   output logic sck_o,
   output logic sck_oe_o,
   input wire logic sdi_i,
   output logic sdo_o,
   input wire logic scl_i,
   output logic scl_o,
   output logic scl_oe_o,
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oe_o,
   output logic irq_o,
   output logic wake_o
);
   import ssp_pkg::*;

   logic [1:0] sck_s, sdi_s, scl_s, sda_s;
   logic sck_d, sda_d;
   logic [7:0] con1_r, buf_r, sh_r, div_r;
   logic samp_end_r, cke_r, ackdt_r, ackstat_r, rcv_r, ackmode_r;
   logic full_r, s_r, p_r, sbit_r;
   logic [2:0] irq_st_r, irq_en_r, bcnt_r, scnt_r;
   logic [1:0] ph_r;
   ssp_st_t st_r;

   ////////////////////////////////////////////////////////////////////////////////////////
   // pin synchronisers; only stage 1 is read, stage 0 feeds nothing else
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         sck_s <= 2'h0;
         sdi_s <= 2'h0;
         scl_s <= 2'h3;
         sda_s <= 2'h3;
         sck_d <= 1'b0;
         sda_d <= 1'b1;
      end else begin
         sck_s <= {sck_s[0], sck_i};
         sdi_s <= {sdi_s[0], sdi_i};
         scl_s <= {scl_s[0], scl_i};
         sda_s <= {sda_s[0], sda_i};
         sck_d <= sck_s[1];
         sda_d <= sda_s[1];
      end
   end

   ////////////////////////////////////////////////////////////////////////////////////////
   // bus decode: answer one cycle after the request is seen
   wire acc = wb_i.cyc & wb_i.stb & ~wb_o.ack;
   wire wr = acc & wb_i.we & wb_i.sel[0];
   wire rd = acc & ~wb_i.we;
   wire [7:0] adr = wb_i.adr;
   wire [7:0] wd = wb_i.dat[7:0];
   wire wr_buf = wr & (adr == `SSP_A_BUF);
   wire wr_con1 = wr & (adr == `SSP_A_CON1);
   wire wr_stat = wr & (adr == `SSP_A_STAT);
   wire wr_cmd = wr & (adr == `SSP_A_CMD);
   wire wr_iclr = wr & (adr == `SSP_A_IRQ_CLR);
   wire wr_ien = wr & (adr == `SSP_A_IRQ_EN);
   wire rd_buf = rd & (adr == `SSP_A_BUF);

   // mode decode
   wire en = con1_r[`SSP_B_EN];
   wire idle_pol = con1_r[`SSP_B_POL];
   wire [3:0] mode = con1_r[3:0];
   wire spim = en & (mode == `SSP_M_SPI_MST);
   wire spis = en & (mode == `SSP_M_SPI_SLV);
   wire i2cm = en & (mode == `SSP_M_I2C_MST);
   wire busy = (st_r != ST_IDLE);
   wire sbusy = spis & (scnt_r != 3'h0);

   // no queueing: a buffer write during any operation is dropped
   wire coll_ev = wr_buf & (busy | sbusy);
   wire go_buf = wr_buf & ~busy & ~sbusy;

   // software actions, one at a time, only while the engine rests
   wire cmd_ok = wr_cmd & i2cm & ~busy;
   wire go_start = cmd_ok & (wd[`SSP_B_SEN] | wd[`SSP_B_RSEN]);
   wire go_stop = cmd_ok & wd[`SSP_B_PEN];
   wire go_rcv = cmd_ok & wd[`SSP_B_RCEN];
   wire go_ack = cmd_ok & wd[`SSP_B_ACKEN];

   // bit-rate divider; slower quarter period in reduced power, frozen in sleep
   wire [7:0] div_lim = lowpow_i ? 8'(DIV_LP - 1) : 8'(DIV_RUN - 1);
   // at or past the limit, so a drop out of reduced power never overshoots and wraps
   wire tick = busy & ~sleep_i & (div_r >= div_lim);

   // slave clock edges seen through the synchroniser
   wire sck_chg = sck_s[1] ^ sck_d;
   wire lead = sck_chg & (sck_d == idle_pol);
   wire trail = sck_chg & (sck_d != idle_pol);
   wire samp_e = spis & (cke_r ? lead : trail);
   wire shft_e = spis & (cke_r ? trail : lead);

   // incoming bit: mid-bit capture or end-of-bit sample
   wire rx_bit = samp_end_r ? sdi_s[1] : sbit_r;
   wire in_bit = spis ? sdi_s[1] : (spim ? rx_bit : sbit_r);
   wire [7:0] sh_in = {sh_r[6:0], in_bit};
   wire last = (bcnt_r == 3'h7);
   wire bit_end_spi = spim & tick & (st_r == ST_BIT) & ph_r[0];
   wire bit_end_i2c = i2cm & tick & (st_r == ST_BIT) & (ph_r == 2'h3);
   wire slv_done = samp_e & (scnt_r == 3'h7);
   wire rx_load = slv_done | (bit_end_spi & last) | (bit_end_i2c & last & rcv_r);
   wire ack_done = i2cm & tick & (st_r == ST_ACK) & (ph_r == 2'h3);
   wire ovf_ev = rx_load & full_r;

   // bus watcher: start and stop seen on the lines
   wire start_det = i2cm & scl_s[1] & sda_d & ~sda_s[1];
   wire stop_det = i2cm & scl_s[1] & ~sda_d & sda_s[1];
   wire xfer_ev = rx_load | ack_done | start_det | stop_det;
   wire [2:0] irq_set = {ovf_ev, coll_ev, xfer_ev};

   // read mux; unmapped and write-only offsets read as zero
   wire [7:0] stat_v = {samp_end_r, cke_r, 1'b0, p_r, s_r, 2'h0, full_r};
   wire [7:0] cmd_v = {busy, ackstat_r, ackdt_r, 5'h00};
   wire [7:0] rdv = (adr == `SSP_A_BUF) ? buf_r :
                    (adr == `SSP_A_CON1) ? con1_r :
                    (adr == `SSP_A_STAT) ? stat_v :
                    (adr == `SSP_A_CMD) ? cmd_v :
                    (adr == `SSP_A_IRQ_ST) ? {5'h00, irq_st_r} :
                    (adr == `SSP_A_IRQ_EN) ? {5'h00, irq_en_r} : 8'h00;

   ////////////////////////////////////////////////////////////////////////////////////////
   // wishbone answer
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_o.ack <= 1'b0;
         wb_o.dat <= 32'h00000000;
      end else begin
         wb_o.ack <= acc;
         wb_o.dat <= acc ? {24'h000000, rdv} : 32'h00000000;
      end
   end

   // control registers; hardware flags win over a clearing write
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         con1_r <= `SSP_RST_REG;
         samp_end_r <= 1'b0;
         cke_r <= 1'b0;
         ackdt_r <= 1'b0;
      end else begin
         con1_r[`SSP_B_COLL] <= coll_ev | (con1_r[`SSP_B_COLL] & ~(wr_con1 & ~wd[7]));
         con1_r[`SSP_B_OV] <= ovf_ev | (con1_r[`SSP_B_OV] & ~(wr_con1 & ~wd[6]));
         if (wr_con1) con1_r[5:0] <= wd[5:0];
         if (wr_stat) samp_end_r <= wd[`SSP_B_SPH];
         if (wr_stat) cke_r <= wd[`SSP_B_CKE];
         if (wr_cmd) ackdt_r <= wd[`SSP_B_ACKDT];
      end
   end

   // receive buffer; an overrun keeps the older byte
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         buf_r <= `SSP_RST_REG;
         full_r <= 1'b0;
      end else begin
         if (rx_load & ~full_r) buf_r <= sh_in;
         full_r <= rx_load | (full_r & ~rd_buf);
      end
   end

   // start/stop seen bits, cleared whenever two-wire master is off
   always_ff @(posedge clk_i) begin
      if (rst_i || !i2cm) begin
         s_r <= 1'b0;
         p_r <= 1'b0;
      end else if (start_det) begin
         s_r <= 1'b1;
         p_r <= 1'b0;
      end else if (stop_det) begin
         s_r <= 1'b0;
         p_r <= 1'b1;
      end
   end

   // interrupt status, clear and enable; wake only where the power state allows it
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         irq_st_r <= `SSP_RST_IRQ;
         irq_en_r <= `SSP_RST_IRQ;
         irq_o <= 1'b0;
         wake_o <= 1'b0;
         scl_o <= 1'b0;
         sda_o <= 1'b0;
      end else begin
         irq_st_r <= irq_set | (irq_st_r & ~(wr_iclr ? wd[2:0] : 3'h0));
         if (wr_ien) irq_en_r <= wd[2:0];
         irq_o <= |(irq_st_r & irq_en_r);
         wake_o <= irq_st_r[`SSP_I_XFER] & irq_en_r[`SSP_I_XFER] &
                   ((spis & sleep_i) | idle_i);
         scl_o <= 1'b0;
         sda_o <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////////////
   // transfer engine; disabling aborts whatever runs, like reset
   always_ff @(posedge clk_i) begin
      if (rst_i || !en) begin
         st_r <= ST_IDLE;
         ph_r <= 2'h0;
         bcnt_r <= 3'h0;
         scnt_r <= 3'h0;
         div_r <= 8'h00;
         sh_r <= 8'h00;
         sbit_r <= 1'b0;
         rcv_r <= 1'b0;
         ackmode_r <= 1'b0;
         ackstat_r <= 1'b0;
         sck_o <= 1'b0;
         sck_oe_o <= 1'b0;
         sdo_o <= 1'b0;
         scl_oe_o <= 1'b0;
         sda_oe_o <= 1'b0;
      end else begin
         sck_oe_o <= spim;
         // sleep holds the divider so the bit in flight keeps its timing
         div_r <= (!busy || tick) ? 8'h00 : (sleep_i ? div_r : div_r + 8'h01);
         if (tick) ph_r <= ph_r + 2'h1;
         // slave shifts on the external clock edges, in any power state
         if (samp_e) begin
            sh_r <= sh_in;
            scnt_r <= scnt_r + 3'h1;
         end
         if (shft_e) sdo_o <= sh_r[7];
         unique case (st_r)
            ST_IDLE: begin
               ph_r <= 2'h0;
               bcnt_r <= 3'h0;
               if (spim) sck_o <= idle_pol;
               if (go_buf) begin
                  sh_r <= wd;
                  sdo_o <= wd[7];
                  rcv_r <= 1'b0;
                  if (!spis) st_r <= ST_BIT;
               end else if (go_start) begin
                  st_r <= ST_START;
               end else if (go_stop) begin
                  st_r <= ST_STOP;
               end else if (go_rcv) begin
                  rcv_r <= 1'b1;
                  st_r <= ST_BIT;
               end else if (go_ack) begin
                  ackmode_r <= 1'b1;
                  st_r <= ST_ACK;
               end
            end
            ST_BIT: begin
               if (tick && spim) begin
                  if (!ph_r[0]) begin
                     sck_o <= ~idle_pol;
                     if (!samp_end_r) sbit_r <= sdi_s[1];
                     if (!cke_r) sdo_o <= sh_r[7];
                  end else begin
                     sck_o <= idle_pol;
                     sh_r <= sh_in;
                     bcnt_r <= bcnt_r + 3'h1;
                     if (cke_r) sdo_o <= sh_r[6];
                     if (last) st_r <= ST_IDLE;
                  end
               end else if (tick) begin
                  // two-wire bit: data while clock low, sample while high
                  unique case (ph_r)
                     2'h0: sda_oe_o <= ~rcv_r & ~sh_r[7];
                     2'h1: scl_oe_o <= 1'b0;
                     2'h2: sbit_r <= sda_s[1];
                     2'h3: begin
                        scl_oe_o <= 1'b1;
                        sh_r <= sh_in;
                        bcnt_r <= bcnt_r + 3'h1;
                        if (last) begin
                           st_r <= rcv_r ? ST_IDLE : ST_ACK;
                           ackmode_r <= 1'b0;
                        end
                     end
                  endcase
               end
            end
            ST_ACK: begin
               // ninth clock: send our acknowledge or read the slave's
               if (tick) begin
                  unique case (ph_r)
                     2'h0: sda_oe_o <= ackmode_r & ~ackdt_r;
                     2'h1: scl_oe_o <= 1'b0;
                     2'h2: if (!ackmode_r) ackstat_r <= sda_s[1];
                     2'h3: begin
                        scl_oe_o <= 1'b1;
                        st_r <= ST_IDLE;
                     end
                  endcase
               end
            end
            ST_START: begin
               // same pattern serves a first start and a repeated start
               if (tick) begin
                  unique case (ph_r)
                     2'h0: sda_oe_o <= 1'b0;
                     2'h1: scl_oe_o <= 1'b0;
                     2'h2: sda_oe_o <= 1'b1;
                     2'h3: begin
                        scl_oe_o <= 1'b1;
                        st_r <= ST_IDLE;
                     end
                  endcase
               end
            end
            ST_STOP: begin
               if (tick) begin
                  unique case (ph_r)
                     2'h0: sda_oe_o <= 1'b1;
                     2'h1: scl_oe_o <= 1'b0;
                     2'h2: sda_oe_o <= 1'b0;
                     2'h3: st_r <= ST_IDLE;
                  endcase
               end
            end
            default: st_r <= ST_IDLE;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////////////////
   // checks
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   sequence s_slave_byte;
      spis && samp_e && scnt_r == 3'h7;
   endsequence
   sequence s_byte_flagged;
      full_r && irq_st_r[`SSP_I_XFER];
   endsequence
   sequence s_stop_seen;
      stop_det;
   endsequence
   sequence s_stop_flagged;
      p_r && !s_r && irq_st_r[`SSP_I_XFER];
   endsequence

   property p_sleep_freeze;
      sleep_i && busy && en && !wr_con1 |=> st_r == $past(st_r) && ph_r == $past(ph_r);
   endproperty
   a_sleep_freeze: assert property (p_sleep_freeze) else $error("transfer moved in sleep");

   property p_wake_idle;
      irq_st_r[`SSP_I_XFER] && irq_en_r[`SSP_I_XFER] && idle_i |=> wake_o;
   endproperty
   a_wake_idle: assert property (p_wake_idle) else $error("no wake from idle");

   property p_no_master_sleep_wake;
      !spis && sleep_i && !idle_i |=> !wake_o;
   endproperty
   a_no_master_sleep_wake: assert property (p_no_master_sleep_wake) else $error("bad wake");

   property p_disable_abort;
      !en |=> st_r == ST_IDLE && !scl_oe_o && !sda_oe_o;
   endproperty
   a_disable_abort: assert property (p_disable_abort) else $error("disable did not abort");

   property p_idle_polarity;
      spim && !busy && !go_buf |=> sck_o == $past(idle_pol);
   endproperty
   a_idle_polarity: assert property (p_idle_polarity) else $error("wrong idle clock");

   property p_slave_byte;
      s_slave_byte |=> s_byte_flagged;
   endproperty
   a_slave_byte: assert property (p_slave_byte) else $error("slave byte not flagged");

   property p_slave_shift;
      samp_e && !go_buf |=> sh_r[0] == $past(sdi_s[1]);
   endproperty
   a_slave_shift: assert property (p_slave_shift) else $error("slave bit lost");

   // without a tick in that cycle the engine cannot have finished, so it must still run
   property p_collision;
      i2cm && busy && wr_buf && !tick |=> con1_r[`SSP_B_COLL] && st_r != ST_IDLE
         ##1 wb_o.ack == 1'b0;
   endproperty
   a_collision: assert property (p_collision) else $error("collision not flagged");

   property p_seen_clear;
      !i2cm |=> !s_r && !p_r;
   endproperty
   a_seen_clear: assert property (p_seen_clear) else $error("seen bits not cleared");

   property p_stop_flag;
      s_stop_seen |=> s_stop_flagged;
   endproperty
   a_stop_flag: assert property (p_stop_flag) else $error("stop not flagged");

   property p_buf_read;
      rd_buf && !rx_load |=> !full_r;
   endproperty
   a_buf_read: assert property (p_buf_read) else $error("full flag stuck");

   // awake cycles spent in stop; sleep may stretch a stop without limit, so it is not counted
   localparam int STOP_MAX = 4 * DIV_LP;
   logic [9:0] stop_age_r;
   always_ff @(posedge clk_i) begin
      if (rst_i || st_r != ST_STOP) begin
         stop_age_r <= 10'h000;
      end else if (!sleep_i) begin
         stop_age_r <= stop_age_r + 10'h001;
      end
   end
   wire stop_late = (stop_age_r > 10'(STOP_MAX));

   property p_stop_cmd;
      go_stop && !go_buf && !go_start |=> st_r == ST_STOP;
   endproperty
   a_stop_cmd: assert property (p_stop_cmd) else $error("stop not run");

   property p_stop_bound;
      st_r == ST_STOP |-> !stop_late;
   endproperty
   a_stop_bound: assert property (p_stop_bound) else $error("stop overran");

   property p_mid_sample;
      spim && tick && st_r == ST_BIT && !ph_r[0] && !samp_end_r |=> sbit_r == $past(sdi_s[1]);
   endproperty
   a_mid_sample: assert property (p_mid_sample) else $error("mid sample missed");
endmodule : ssp_top

/* sim/ssp_far_model.sv */
/* Far side of the sync serial port: serial peripheral that loops data back in master
   role or clocks a byte in as master, and pull-ups on the two-wire lines.
   Assumes the bench calls send() while the port sits in slave role. */
module ssp_far_model (
   input wire logic loop_i,
   input wire logic dev_sdo_i,
   input wire logic dev_scl_oe_i,
   input wire logic dev_sda_oe_i,
   output logic sck_o,
   output logic sdi_o,
   output logic scl_o,
   output logic sda_o
);
   timeunit 1ns;
   timeprecision 1ps;
   logic ck = 1'h0;
   logic sd = 1'h0;
   ////////////////////////////////////////////////////////////////////////////////
   // open drain with pull-ups, so a released line reads high
   assign scl_o = ~dev_scl_oe_i;
   assign sda_o = ~dev_sda_oe_i;
   // loopback in master role, own line otherwise; clock stands idle between frames
   assign sdi_o = loop_i ? dev_sdo_i : sd;
   assign sck_o = ck;
   ////////////////////////////////////////////////////////////////////////////////
   // mode 0,0 frame, msb first, data set while clock low, 64 ns period
   task automatic send(input logic [7:0] b);
      for (int i = 7; i >= 0; i--) begin
         sd = b[i];
         #32 ck = 1'h1;
         #32 ck = 1'h0;
      end
      sd = ~b[0];  // hold is over, so the line no longer shows the last bit
   endtask : send
endmodule : ssp_far_model

/* sim/tb.sv */
/* Self-checking bench of the sync serial port: register access over classic Wishbone.
   Assumes the offsets and bit layout of the constants header and a 125 MHz clock. */
`include "ssp_params.svh"
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   import ssp_pkg::*;
   logic clk_i = 1'h0, rst_i = 1'h1, sleep_i = 1'h0, idle_i = 1'h0, lowpow_i = 1'h0;
   logic lb = 1'h1, s;
   ssp_wb_req_t wb_i = '0;
   ssp_wb_rsp_t wb_o;
   logic sck_i, sdi_i, scl_i, sda_i, sck_o, sck_oe_o, sdo_o, scl_o, scl_oe_o;
   logic sda_o, sda_oe_o, irq_o, wake_o;
   logic [7:0] q, d;
   logic [7:0] ca [4] = '{`SSP_A_BUF, `SSP_A_CMD, `SSP_A_CMD, `SSP_A_CMD};
   logic [7:0] cd [4] = '{8'h5A, 8'h08, 8'h30, 8'h02};
   int err_total = 0, comparisons = 0, chg;
   ////////////////////////////////////////////////////////////////////////////////
   // small dividers keep each serial byte short
   ssp_top #(.DIV_RUN(4), .DIV_LP(8)) DUT (.clk_i(clk_i), .rst_i(rst_i), .wb_i(wb_i),
      .wb_o(wb_o), .sleep_i(sleep_i), .idle_i(idle_i), .lowpow_i(lowpow_i),
      .sck_i(sck_i), .sck_o(sck_o), .sck_oe_o(sck_oe_o), .sdi_i(sdi_i), .sdo_o(sdo_o),
      .scl_i(scl_i), .scl_o(scl_o), .scl_oe_o(scl_oe_o), .sda_i(sda_i), .sda_o(sda_o),
      .sda_oe_o(sda_oe_o), .irq_o(irq_o), .wake_o(wake_o));
   ssp_far_model far (.loop_i(lb), .dev_sdo_i(sdo_o), .dev_scl_oe_i(scl_oe_o),
      .dev_sda_oe_i(sda_oe_o), .sck_o(sck_i), .sdi_o(sdi_i), .scl_o(scl_i), .sda_o(sda_i));
   // 8 ns clock
   initial begin
      forever #4 clk_i = ~clk_i;
   end
   ////////////////////////////////////////////////////////////////////////////////
   // every call starts and ends just after a rising edge
   task chk(input string nm, input logic [7:0] e, input logic [7:0] g);
      comparisons++;
      if (g !== e) begin
         err_total++;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   // one classic cycle; held until ack is sampled, read data taken at that edge
   task bus(input logic w, input logic [7:0] a, input logic [7:0] v);
      int n;
      n = 0;
      wb_i <= '{cyc: 1'h1, stb: 1'h1, we: w, adr: a, sel: 4'hF, dat: {24'h0, v}};
      do begin
         @(posedge clk_i);
         n++;
      end while (wb_o.ack !== 1'h1 && n < 50);
      if (n >= 50) chk("bus ack", 8'h01, 8'h00);
      q = wb_o.dat[7:0];
      wb_i <= '0;
      @(posedge clk_i);
   endtask : bus
   task rd(input logic [7:0] a, input logic [7:0] e, input string nm);
      bus(1'h0, a, 8'h00);
      chk(nm, e, q);
   endtask : rd
   // polls the interrupt status register; a limit keeps a lost event from hanging the run
   task poll(input logic [7:0] m);
      int n;
      n = 0;
      do begin
         bus(1'h0, `SSP_A_IRQ_ST, 8'h00);
         n++;
      end while ((q & m) === 8'h00 && n < 400);
      chk("event seen", m, q & m);
   endtask : poll
   task complete_run;
      $display("comparisons %0d mismatches %0d", comparisons, err_total);
      if (err_total == 0 && comparisons > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : complete_run
   ////////////////////////////////////////////////////////////////////////////////
   // main sequence
   initial begin
      repeat (16) @(posedge clk_i);
      rst_i <= 1'h0;
      @(posedge clk_i);
      rd(`SSP_A_CON1, 8'h00, "con1 reset");
      rd(`SSP_A_IRQ_EN, 8'h00, "irq enable reset");
      bus(1'h1, 8'h1C, 8'hFF);
      rd(8'h1C, 8'h00, "unmapped");
      $display("test reset_values done");
      // master loopback in both idle polarities, second write collides
      for (int p = 0; p < 2; p++) begin
         d = p ? 8'h3C : 8'hA5;
         bus(1'h1, `SSP_A_STAT, {p[0], 7'h40}); // second pass samples at bit end
         bus(1'h1, `SSP_A_CON1, {3'h1, p[0], 4'h0});
         bus(1'h1, `SSP_A_IRQ_EN, 8'h01);
         bus(1'h1, `SSP_A_BUF, d);
         bus(1'h1, `SSP_A_BUF, 8'h11);
         poll(8'h01);
         chk("irq out", 8'h01, {7'h0, irq_o});
         chk("sck idle", {7'h0, p[0]}, {7'h0, sck_o});
         rd(`SSP_A_IRQ_ST, 8'h03, "irq status");
         rd(`SSP_A_STAT, {p[0], 7'h41}, "full set");
         rd(`SSP_A_BUF, d, "loopback");
         rd(`SSP_A_STAT, {p[0], 7'h40}, "full clear");
         bus(1'h1, `SSP_A_IRQ_CLR, 8'h07);
         bus(1'h1, `SSP_A_CON1, 8'h00);
         chk("irq cleared", 8'h00, {7'h0, irq_o});
      end
      $display("test master_loopback done");
      // sleep freezes a running transfer; completion wakes only from idle
      bus(1'h1, `SSP_A_CON1, 8'h20);
      bus(1'h1, `SSP_A_BUF, 8'h96);
      sleep_i <= 1'h1;
      repeat (3) @(posedge clk_i);
      s = sck_o;
      chg = 0;
      repeat (40) begin
         @(posedge clk_i);
         if (sck_o !== s) chg++;
      end
      chk("frozen sck", 8'h00, chg[7:0]);
      // resume at the reduced-power rate: one sck edge per 8 clocks
      sleep_i <= 1'h0;
      lowpow_i <= 1'h1;
      chg = 0;
      repeat (64) begin
         @(posedge clk_i);
         if (sck_o !== s) chg++;
         s = sck_o;
      end
      chk("slow sck edges", 8'h08, chg[7:0]);
      lowpow_i <= 1'h0;
      bus(1'h1, `SSP_A_IRQ_EN, 8'h01);
      poll(8'h01);
      rd(`SSP_A_BUF, 8'h96, "resumed byte");
      idle_i <= 1'h1;
      repeat (3) @(posedge clk_i);
      chk("wake idle", 8'h01, {7'h0, wake_o});
      idle_i <= 1'h0;
      sleep_i <= 1'h1;
      repeat (3) @(posedge clk_i);
      chk("wake master sleep", 8'h00, {7'h0, wake_o});
      sleep_i <= 1'h0;
      bus(1'h1, `SSP_A_IRQ_CLR, 8'h07);
      $display("test sleep_wake done");
      // slave byte arrives during sleep and wakes the device
      bus(1'h1, `SSP_A_CON1, 8'h24);
      lb <= 1'h0;
      sleep_i <= 1'h1;
      @(posedge clk_i);
      far.send(8'hC3);
      repeat (8) @(posedge clk_i);
      chk("wake slave sleep", 8'h01, {7'h0, wake_o});
      sleep_i <= 1'h0;
      poll(8'h01);
      rd(`SSP_A_BUF, 8'hC3, "slave byte");
      bus(1'h1, `SSP_A_IRQ_CLR, 8'h07);
      $display("test slave done");
      // reset in mid transfer aborts it and disables the port
      lb <= 1'h1;
      bus(1'h1, `SSP_A_CON1, 8'h20);
      bus(1'h1, `SSP_A_BUF, 8'hFF);
      rst_i <= 1'h1;
      @(posedge clk_i);
      rst_i <= 1'h0;
      @(posedge clk_i);
      chk("sck drive", 8'h00, {7'h0, sck_oe_o});
      repeat (100) @(posedge clk_i);
      rd(`SSP_A_IRQ_ST, 8'h00, "aborted");
      rd(`SSP_A_CON1, 8'h00, "disabled");
      $display("test reset_abort done");
      // two-wire master: start, collision, send, receive, ack, repeated start, stop
      bus(1'h1, `SSP_A_CON1, 8'h28);
      rd(`SSP_A_STAT, 8'h00, "bus idle");
      bus(1'h1, `SSP_A_CMD, 8'h01);
      bus(1'h1, `SSP_A_BUF, 8'h5A);
      poll(8'h01);
      rd(`SSP_A_STAT, 8'h08, "start seen");
      rd(`SSP_A_CON1, 8'hA8, "collision");
      // interrupt left disabled: idle must not be left
      idle_i <= 1'h1;
      repeat (3) @(posedge clk_i);
      chk("no wake masked", 8'h00, {6'h0, wake_o, irq_o});
      idle_i <= 1'h0;
      bus(1'h1, `SSP_A_CON1, 8'h28);
      for (int i = 0; i < 4; i++) begin
         bus(1'h1, `SSP_A_IRQ_CLR, 8'h07);
         bus(1'h1, ca[i], cd[i]);
         poll(8'h01);
      end
      bus(1'h1, `SSP_A_IRQ_CLR, 8'h07);
      bus(1'h1, `SSP_A_CMD, 8'h04);
      poll(8'h01);
      bus(1'h0, `SSP_A_STAT, 8'h00);
      chk("stop seen", 8'h10, q & 8'h10);
      bus(1'h1, `SSP_A_CON1, 8'h08);
      // the received byte is still unread, so only buffer full remains
      rd(`SSP_A_STAT, 8'h01, "seen bits off");
      rd(`SSP_A_BUF, 8'hFF, "two-wire rx");
      chk("lines free", 8'h00, {4'h0, scl_o, sda_o, scl_oe_o, sda_oe_o});
      $display("test two_wire done");
      complete_run();
   end
   // watchdog well beyond the expected run length
   initial begin
      repeat (40000) @(posedge clk_i);
      chk("watchdog", 8'h00, 8'h01);
      complete_run();
   end
endmodule : tb
